/* File: hw/tlbri_pkg.sv */
// constants for the stage 1 tlb invalidation block: opcodes, regimes, command fields, register map
// assumes one 50 MHz clock shared by the command queue, the table walker and software
package tlbri_pkg;
  // command opcodes; only monitor and hyp flush-all codes are fixed by the queue format
  localparam logic [7:0] OP_GUEST_EL1_FLUSH_ALL = 8'h10;
  localparam logic [7:0] OP_GUEST_EL1_FLUSH_BY_TAG = 8'h11;
  localparam logic [7:0] OP_GUEST_EL1_FLUSH_ADDR = 8'h12;
  localparam logic [7:0] OP_GUEST_EL1_FLUSH_ADDR_ALL_TAGS = 8'h13;
  localparam logic [7:0] OP_MONITOR_FLUSH_ALL = 8'h18;
  localparam logic [7:0] OP_MONITOR_FLUSH_ADDR = 8'h1a;
  localparam logic [7:0] OP_HYP_FLUSH_ALL = 8'h20;
  localparam logic [7:0] OP_HYP_FLUSH_BY_TAG = 8'h21;
  localparam logic [7:0] OP_HYP_FLUSH_ADDR = 8'h22;
  localparam logic [7:0] OP_HYP_FLUSH_ADDR_ALL_TAGS = 8'h23;
  // stream regime of a cached entry
  localparam int RG_W = 3;
  localparam logic [2:0] RG_NS_EL1 = 3'h0;
  localparam logic [2:0] RG_SECURE = 3'h1;
  localparam logic [2:0] RG_MONITOR = 3'h2;
  localparam logic [2:0] RG_HYP = 3'h3;
  localparam logic [2:0] RG_HYP_HOST = 3'h4;
  // granule_selector codes
  localparam logic [1:0] TG_ANY = 2'h0;
  localparam logic [1:0] TG_4K = 2'h1;
  localparam logic [1:0] TG_16K = 2'h2;
  localparam logic [1:0] TG_64K = 2'h3;
  // command word field positions
  localparam int F_OP_LSB = 0;
  localparam int F_LEAF = 9;
  localparam int F_NUM_LSB = 12;
  localparam int F_SCALE_LSB = 20;
  localparam int F_VMT_LSB = 32;
  localparam int F_AST_LSB = 48;
  localparam int F_TTL_LSB = 72;
  localparam int F_TG_LSB = 74;
  localparam int F_ADDR_LSB = 76;
  // register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_VALID = 8'h08;
  localparam logic [7:0] REG_ERRCNT = 8'h0c;
  localparam int CB_RIL = 0;
  localparam int CB_HYP = 1;
  localparam int CB_BTM = 2;
  localparam int CB_E2H = 3;
  localparam int CB_S1 = 4;
  localparam int CB_NS_S2 = 5;
  localparam int CB_S_S2 = 6;
  localparam int CTRL_W = 7;
  localparam logic [6:0] CTRL_RST = 7'h17;
  typedef enum logic [1:0] {
    TLBRI_IDLE = 2'b01,
    TLBRI_EXEC = 2'b10
  } tlbri_state_t;
endpackage : tlbri_pkg

/* File: hw/tlbri_match.sv */
// per-entry match of one cached translation against a decoded invalidation scope
// assumes the scope is stable for the cycle in which the parent applies the hit
`timescale 1ns/1ns
module tlbri_match #(
  parameter int PW = 36,
  parameter int XW = 78
) (
  input wire logic [tlbri_pkg::RG_W-1:0] e_regime, // entry stream regime
  input wire logic [15:0] e_vmt, // entry virtual machine tag
  input wire logic [15:0] e_ast, // entry address space tag
  input wire logic e_glob, // entry is global
  input wire logic [1:0] e_tg, // granule the entry was filled with
  input wire logic [1:0] e_lvl, // walk level of the entry
  input wire logic e_table, // entry caches a table descriptor
  input wire logic [5:0] e_span, // log2 of pages covered
  input wire logic [PW-1:0] e_va, // entry base page
  input wire logic [7:0] c_mask, // regimes in scope
  input wire logic c_vmt_chk, // compare virtual machine tag
  input wire logic [15:0] c_vmt, // command virtual machine tag
  input wire logic c_ast_chk, // compare address space tag
  input wire logic [15:0] c_ast, // command address space tag
  input wire logic c_nonglob, // global entries excluded
  input wire logic c_by_addr, // address based command
  input wire logic [1:0] c_tg, // effective granule selector
  input wire logic [1:0] c_hint, // effective level hint
  input wire logic c_leaf, // last level only
  input wire logic [XW-1:0] c_start, // first page
  input wire logic [XW-1:0] c_end, // page past the last
  output logic hit // entry must be dropped
);
  import tlbri_pkg::*;
  logic [XW-1:0] eb;
  logic [XW-1:0] ee;
  logic tag_ok;
  logic adr_ok;
  logic tg_ok;
  logic lvl_ok;
  always_comb begin
    eb = XW'(e_va);
    ee = eb + (XW'(1) << e_span);
    tag_ok = (!c_vmt_chk || e_vmt == c_vmt) && (!c_ast_chk || (e_glob ? !c_nonglob : e_ast == c_ast));
    adr_ok = !c_by_addr || (eb < c_end && ee > c_start); // R6
    tg_ok = !c_by_addr || c_tg == TG_ANY || e_tg == c_tg; // R21
    // tables above the hinted leaf level go too unless leaf-only
    if (!c_by_addr) begin
      lvl_ok = 1'b1;
    end else if (e_table) begin
      lvl_ok = !c_leaf && (c_hint == 2'h0 || e_lvl < c_hint); // R4
    end else begin
      lvl_ok = c_hint == 2'h0 || e_lvl == c_hint; // R2
    end
    hit = c_mask[e_regime] && tag_ok && adr_ok && tg_ok && lvl_ok;
  end
endmodule : tlbri_match

/* File: hw/tlbri_top.sv */
// stage 1 tlb invalidation: decodes one queued command, drops matching cached entries
// assumes command, fill and register ports are driven from core_clk logic
// Contract
// R1 - granule selector zero: hint ignored, no range, any level and granule.
// R2 - nonzero granule: hint 1/2/3 restricts leaf entries to that level; 0 any.
// R3 - 16KB granule with level 1 hint is treated as hint zero.
// R4 - leaf flag clear: table entries above hinted level are dropped too.
// R5 - range is (count+1) times two to the exponent times granule size.
// R6 - invalidate address up to address plus range, never wrapping.
// R7 - 4KB: software keeps low address bits zero for level 1 and 2 hints.
// R8 - 16KB: software keeps low address bits zero for each hint.
// R9 - 64KB: software keeps low address bits zero for each hint.
// R10 - nonzero granule, zero count, exponent and hint raises illegal command error.
// R11 - revision 3.2 or later with broadcast support accepts broadcast range operations.
// R12 - stage 2 only device rejects every stage 1 command.
// R13 - monitor commands illegal on nonsecure queue; secure queue drops monitor entries.
// R14 - hyp commands follow host extension control, illegal without hypervisor support.
// R15 - guest commands drop nonsecure EL1 or secure regime entries by queue.
// R16 - virtual machine tag compared only when the queue has stage 2.
// R17 - guest addresses are virtual; out of range addresses may be ignored.
// R18 - nonsecure guest flush-all drops EL1 entries of the tag, globals included.
// R19 - secure guest flush-all without secure stage 2 drops all secure entries.
// R20 - secure guest flush-all with secure stage 2 matches the tag.
// R21 - granule codes 4KB, 16KB, 64KB; only matching granule entries dropped.
// R22 - exponent in bits 24:20, count in 16:12, zero when granule zero.
// R23 - granule in bits 75:74, hint in 73:72; hint never widens scope.
// R24 - without range support all range and hint fields read as zero.
// R25 - illegal command invalidates nothing and is flagged on its own queue.
`timescale 1ns/1ns
module tlbri_top #(
  parameter int ENTRIES = 8,
  parameter int VA_W = 48,
  parameter int REV_MAJ = 3,
  parameter int REV_MIN = 2,
  parameter bit TBI_EN = 1'b1,
  localparam int IW = $clog2(ENTRIES)
) (
  input wire logic core_clk, // block clock
  input wire logic rst_n, // synchronous reset
  input wire logic ce, // freezes all state when low
  input wire logic [tlbri_pkg::ADDR_W-1:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  input wire logic cmd_valid, // command offered
  input wire logic [127:0] cmd_word, // command word
  input wire logic cmd_secure, // command from secure queue
  input wire logic cmd_bcast, // command is a broadcast operation
  output logic cmd_ready, // command taken when valid and ready
  input wire logic fill_valid, // walker writes an entry
  input wire logic [IW-1:0] fill_idx, // entry slot
  input wire logic [tlbri_pkg::RG_W-1:0] fill_regime, // stream regime
  input wire logic [15:0] fill_vmt, // virtual machine tag
  input wire logic [15:0] fill_ast, // address space tag
  input wire logic fill_global, // global entry
  input wire logic [1:0] fill_tg, // granule used
  input wire logic [1:0] fill_level, // walk level
  input wire logic fill_table, // table descriptor entry
  input wire logic [5:0] fill_span, // log2 pages covered
  input wire logic [VA_W-13:0] fill_va_page, // base page, aligned to span
  output logic ns_cmd_err, // illegal command pulse, nonsecure queue
  output logic s_cmd_err, // illegal command pulse, secure queue
  output logic cmd_done, // accepted command finished
  output logic [ENTRIES-1:0] entry_valid // live entries
);
  import tlbri_pkg::*;
  localparam int PW = VA_W - 12;
  localparam int XW = PW + 42;
  localparam bit REV_OK = (REV_MAJ > 3) || (REV_MAJ == 3 && REV_MIN >= 2);

  tlbri_state_t st_reg;
  tlbri_state_t st_next;
  logic [127:0] cw_reg;
  logic [127:0] cw_next;
  logic sec_reg;
  logic sec_next;
  logic bc_reg;
  logic bc_next;
  logic rdy_reg;
  logic rdy_next;
  logic done_reg;
  logic done_next;
  logic nserr_reg;
  logic nserr_next;
  logic serr_reg;
  logic serr_next;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [CTRL_W-1:0] ctrl_next;
  logic [15:0] ecnt_reg;
  logic [15:0] ecnt_next;
  logic lsec_reg;
  logic lsec_next;
  logic [31:0] rd_reg;
  logic [31:0] rd_next;
  logic [ENTRIES-1:0] ev_reg;
  logic [ENTRIES-1:0] ev_next;
  logic [RG_W-1:0] rg_reg [ENTRIES];
  logic [RG_W-1:0] rg_next [ENTRIES];
  logic [15:0] vm_reg [ENTRIES];
  logic [15:0] vm_next [ENTRIES];
  logic [15:0] as_reg [ENTRIES];
  logic [15:0] as_next [ENTRIES];
  logic [1:0] tg_reg [ENTRIES];
  logic [1:0] tg_next [ENTRIES];
  logic [1:0] lv_reg [ENTRIES];
  logic [1:0] lv_next [ENTRIES];
  logic [5:0] sp_reg [ENTRIES];
  logic [5:0] sp_next [ENTRIES];
  logic [PW-1:0] va_reg [ENTRIES];
  logic [PW-1:0] va_next [ENTRIES];
  logic [ENTRIES-1:0] gl_reg;
  logic [ENTRIES-1:0] gl_next;
  logic [ENTRIES-1:0] tb_reg;
  logic [ENTRIES-1:0] tb_next;
  // decoded scope of the held command
  logic [7:0] op;
  logic ril;
  logic [1:0] tg_e;
  logic [1:0] hint_e;
  logic [4:0] num_e;
  logic [4:0] scale_e;
  logic [1:0] gsh;
  logic [51:0] addr;
  logic s2_q;
  logic ill;
  logic drop;
  logic oor;
  logic by_addr;
  logic vmt_chk;
  logic ast_chk;
  logic nonglob;
  logic [7:0] mask;
  logic [XW-1:0] c_start;
  logic [XW-1:0] c_end;
  logic [ENTRIES-1:0] hits;
  logic [ENTRIES-1:0] kill;

  always_comb begin
    op = cw_reg[F_OP_LSB +: 8];
    ril = ctrl_reg[CB_RIL];
    tg_e = ril ? cw_reg[F_TG_LSB +: 2] : TG_ANY; // R24 R23
    hint_e = (tg_e != TG_ANY) ? cw_reg[F_TTL_LSB +: 2] : 2'h0; // R1
    if (tg_e == TG_16K && hint_e == 2'h1) begin
      hint_e = 2'h0; // R3
    end
    num_e = (tg_e != TG_ANY) ? cw_reg[F_NUM_LSB +: 5] : 5'h0; // R22
    scale_e = (tg_e != TG_ANY) ? cw_reg[F_SCALE_LSB +: 5] : 5'h0; // R22
    gsh = (tg_e == TG_64K) ? 2'h2 : ((tg_e == TG_16K) ? 2'h1 : 2'h0);
    addr = cw_reg[F_ADDR_LSB +: 52];
    s2_q = sec_reg ? ctrl_reg[CB_S_S2] : ctrl_reg[CB_NS_S2];
    // addresses are virtual: differing upper bits put the command out of range
    oor = TBI_EN ? !(&addr[43:PW-1] || ~|addr[43:PW-1]) : !(&addr[51:PW-1] || ~|addr[51:PW-1]); // R17
    // range in pages; end is wide so it cannot wrap into the low half
    c_start = XW'(addr[PW-1:0]);
    c_end = c_start + ((XW'(num_e) + XW'(1)) << (7'(scale_e) + 7'({gsh, 1'b0}))); // R5 R6
    drop = bc_reg && !(ctrl_reg[CB_BTM] && REV_OK); // R11
    ill = 1'b0;
    by_addr = 1'b0;
    vmt_chk = 1'b0;
    ast_chk = 1'b0;
    nonglob = 1'b0;
    mask = 8'h00;
    unique case (op)
      OP_GUEST_EL1_FLUSH_ALL, OP_GUEST_EL1_FLUSH_BY_TAG,
      OP_GUEST_EL1_FLUSH_ADDR, OP_GUEST_EL1_FLUSH_ADDR_ALL_TAGS: begin
        mask[sec_reg ? RG_SECURE : RG_NS_EL1] = 1'b1; // R15 R18 R19
        vmt_chk = s2_q; // R16 R20
        ast_chk = op == OP_GUEST_EL1_FLUSH_BY_TAG || op == OP_GUEST_EL1_FLUSH_ADDR;
        nonglob = op == OP_GUEST_EL1_FLUSH_BY_TAG;
        by_addr = op == OP_GUEST_EL1_FLUSH_ADDR || op == OP_GUEST_EL1_FLUSH_ADDR_ALL_TAGS;
      end
      OP_MONITOR_FLUSH_ALL, OP_MONITOR_FLUSH_ADDR: begin
        ill = !sec_reg; // R13
        mask[RG_MONITOR] = 1'b1;
        by_addr = op == OP_MONITOR_FLUSH_ADDR;
      end
      OP_HYP_FLUSH_ALL: begin
        ill = !ctrl_reg[CB_HYP]; // R14
        mask[RG_HYP] = 1'b1;
        mask[RG_HYP_HOST] = 1'b1;
      end
      OP_HYP_FLUSH_BY_TAG: begin
        ill = !ctrl_reg[CB_HYP]; // R14
        mask[RG_HYP_HOST] = 1'b1;
        ast_chk = 1'b1;
        nonglob = 1'b1;
      end
      OP_HYP_FLUSH_ADDR, OP_HYP_FLUSH_ADDR_ALL_TAGS: begin
        ill = !ctrl_reg[CB_HYP]; // R14
        mask[ctrl_reg[CB_E2H] ? RG_HYP_HOST : RG_HYP] = 1'b1;
        ast_chk = op == OP_HYP_FLUSH_ADDR && ctrl_reg[CB_E2H];
        by_addr = 1'b1;
      end
      default: ill = 1'b1;
    endcase
    if (by_addr && tg_e != TG_ANY && num_e == 5'h0 && scale_e == 5'h0 && hint_e == 2'h0) begin
      ill = 1'b1; // R10
    end
    if (!ctrl_reg[CB_S1]) begin
      ill = 1'b1; // R12
    end
  end

  for (genvar g = 0; g < ENTRIES; g++) begin : g_ent
    tlbri_match #(.PW(PW), .XW(XW)) u_match (
      .e_regime(rg_reg[g]),
      .e_vmt(vm_reg[g]),
      .e_ast(as_reg[g]),
      .e_glob(gl_reg[g]),
      .e_tg(tg_reg[g]),
      .e_lvl(lv_reg[g]),
      .e_table(tb_reg[g]),
      .e_span(sp_reg[g]),
      .e_va(va_reg[g]),
      .c_mask(mask),
      .c_vmt_chk(vmt_chk),
      .c_vmt(cw_reg[F_VMT_LSB +: 16]),
      .c_ast_chk(ast_chk),
      .c_ast(cw_reg[F_AST_LSB +: 16]),
      .c_nonglob(nonglob),
      .c_by_addr(by_addr),
      .c_tg(tg_e),
      .c_hint(hint_e),
      .c_leaf(cw_reg[F_LEAF]),
      .c_start(c_start),
      .c_end(c_end),
      .hit(hits[g])
    );
  end

  // rejected, dropped or out of range commands touch nothing
  assign kill = hits & ev_reg & {ENTRIES{st_reg == TLBRI_EXEC && !ill && !drop && !(by_addr && oor)}}; // R25

  // a fill in the same cycle as an invalidate wins: the entry is fresh
  always_comb begin
    ev_next = ev_reg & ~kill;
    rg_next = rg_reg;
    vm_next = vm_reg;
    as_next = as_reg;
    tg_next = tg_reg;
    lv_next = lv_reg;
    sp_next = sp_reg;
    va_next = va_reg;
    gl_next = gl_reg;
    tb_next = tb_reg;
    if (fill_valid) begin
      ev_next[fill_idx] = 1'b1;
      rg_next[fill_idx] = fill_regime;
      vm_next[fill_idx] = fill_vmt;
      as_next[fill_idx] = fill_ast;
      tg_next[fill_idx] = fill_tg;
      lv_next[fill_idx] = fill_level;
      sp_next[fill_idx] = fill_span;
      va_next[fill_idx] = fill_va_page;
      gl_next[fill_idx] = fill_global;
      tb_next[fill_idx] = fill_table;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ev_reg <= '0;
    end else if (ce) begin
      ev_reg <= ev_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (ce) begin
      rg_reg <= rg_next;
      vm_reg <= vm_next;
      as_reg <= as_next;
      tg_reg <= tg_next;
      lv_reg <= lv_next;
      sp_reg <= sp_next;
      va_reg <= va_next;
      gl_reg <= gl_next;
      tb_reg <= tb_next;
    end
  end

  always_comb begin
    st_next = st_reg;
    cw_next = cw_reg;
    sec_next = sec_reg;
    bc_next = bc_reg;
    rdy_next = rdy_reg;
    done_next = 1'b0;
    nserr_next = 1'b0;
    serr_next = 1'b0;
    unique case (st_reg)
      TLBRI_IDLE: begin
        if (cmd_valid && rdy_reg) begin
          cw_next = cmd_word;
          sec_next = cmd_secure;
          bc_next = cmd_bcast;
          rdy_next = 1'b0;
          st_next = TLBRI_EXEC;
        end
      end
      TLBRI_EXEC: begin
        done_next = !ill;
        nserr_next = ill && !sec_reg; // R25
        serr_next = ill && sec_reg; // R25
        rdy_next = 1'b1;
        st_next = TLBRI_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_reg <= TLBRI_IDLE;
      cw_reg <= '0;
      sec_reg <= 1'b0;
      bc_reg <= 1'b0;
      rdy_reg <= 1'b1;
      done_reg <= 1'b0;
      nserr_reg <= 1'b0;
      serr_reg <= 1'b0;
    end else if (ce) begin
      st_reg <= st_next;
      cw_reg <= cw_next;
      sec_reg <= sec_next;
      bc_reg <= bc_next;
      rdy_reg <= rdy_next;
      done_reg <= done_next;
      nserr_reg <= nserr_next;
      serr_reg <= serr_next;
    end
  end

  // error count: a clear in the cycle of a new error leaves a count of one
  always_comb begin
    ctrl_next = ctrl_reg;
    ecnt_next = ecnt_reg;
    lsec_next = lsec_reg;
    rd_next = 32'h0000_0000;
    if (reg_wr && reg_addr == REG_CTRL) begin
      ctrl_next = reg_wdata[CTRL_W-1:0];
    end
    if (reg_wr && reg_addr == REG_ERRCNT) begin
      ecnt_next = 16'h0000;
    end
    if (st_reg == TLBRI_EXEC && ill) begin
      ecnt_next = ecnt_next + 16'h0001;
      lsec_next = sec_reg;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL: rd_next = 32'(ctrl_reg);
        REG_STATUS: rd_next = {29'h0, ctrl_reg[CB_BTM] && REV_OK, lsec_reg, st_reg == TLBRI_EXEC};
        REG_VALID: rd_next = 32'(ev_reg);
        REG_ERRCNT: rd_next = {16'h0000, ecnt_reg};
        default: rd_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RST;
      ecnt_reg <= 16'h0000;
      lsec_reg <= 1'b0;
      rd_reg <= 32'h0000_0000;
    end else if (ce) begin
      ctrl_reg <= ctrl_next;
      ecnt_reg <= ecnt_next;
      lsec_reg <= lsec_next;
      rd_reg <= rd_next;
    end
  end

  assign reg_rdata = rd_reg;
  assign cmd_ready = rdy_reg;
  assign cmd_done = done_reg;
  assign ns_cmd_err = nserr_reg;
  assign s_cmd_err = serr_reg;
  assign entry_valid = ev_reg;

  chk_ill_no_inval: assert property (@(posedge core_clk) disable iff (!rst_n) // R25
    (ce && st_reg == TLBRI_EXEC && ill && !fill_valid) |=> (ev_reg == $past(ev_reg)))
    else $error("illegal command dropped entries");
  chk_reserved_combo: assert property (@(posedge core_clk) disable iff (!rst_n) // R10
    (ce && st_reg == TLBRI_EXEC && by_addr && tg_e != TG_ANY && num_e == 5'h0 && scale_e == 5'h0
     && hint_e == 2'h0) |=> (ns_cmd_err || s_cmd_err))
    else $error("reserved range encoding not rejected");
  chk_stage1_absent: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
    (ce && st_reg == TLBRI_EXEC && !ctrl_reg[CB_S1]) |=> (ns_cmd_err || s_cmd_err) && !cmd_done)
    else $error("stage 1 command accepted without stage 1");
  chk_monitor_ns: assert property (@(posedge core_clk) disable iff (!rst_n) // R13
    (ce && st_reg == TLBRI_EXEC && !sec_reg && (op == OP_MONITOR_FLUSH_ALL || op == OP_MONITOR_FLUSH_ADDR))
    |=> ns_cmd_err && !s_cmd_err)
    else $error("monitor command on nonsecure queue not rejected");
  chk_hyp_absent: assert property (@(posedge core_clk) disable iff (!rst_n) // R14
    (ce && st_reg == TLBRI_EXEC && !ctrl_reg[CB_HYP] && op[7:2] == 6'h08) |=> (ns_cmd_err || s_cmd_err))
    else $error("hyp command accepted without hypervisor support");
  chk_err_one_queue: assert property (@(posedge core_clk) disable iff (!rst_n) // R25
    !(ns_cmd_err && s_cmd_err) && !(cmd_done && (ns_cmd_err || s_cmd_err)))
    else $error("error reported on both queues or with done");
  chk_hint_16k: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
    (ril && cw_reg[F_TG_LSB +: 2] == TG_16K && cw_reg[F_TTL_LSB +: 2] == 2'h1) |-> hint_e == 2'h0)
    else $error("reserved 16KB level 1 hint not treated as zero");
  chk_no_range_supp: assert property (@(posedge core_clk) disable iff (!rst_n) // R24
    !ril |-> (tg_e == TG_ANY && hint_e == 2'h0 && num_e == 5'h0 && scale_e == 5'h0))
    else $error("range fields used without range support");
  chk_range_nowrap: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
    (st_reg == TLBRI_EXEC) |-> (c_end > c_start))
    else $error("invalidation range wrapped");
  chk_ready_return: assert property (@(posedge core_clk) disable iff (!rst_n) // R25
    (ce && cmd_valid && cmd_ready) |=> !cmd_ready ##1 (cmd_ready || !ce))
    else $error("command handshake timing broken");
endmodule : tlbri_top

/* File: tb/tlbri_cmd_src.sv */
// behavioural software side: offers one command word at a time on the queue port
// assumes cmd_ready is sampled at core_clk rising edges
`timescale 1ns/1ns
module tlbri_cmd_src (
  input wire logic core_clk, // block clock
  input wire logic cmd_ready, // block can take a command
  output logic cmd_valid, // command offered
  output logic [127:0] cmd_word, // command word
  output logic cmd_secure, // secure queue
  output logic cmd_bcast // broadcast operation
);
  initial begin
    cmd_valid = 1'b0;
    cmd_word = '1;
    cmd_secure = 1'b0;
    cmd_bcast = 1'b0;
  end
  // callers keep address low bits aligned to the hinted level
  task send(input logic [127:0] w, input logic sec, input logic bc);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_word <= w;
    cmd_secure <= sec;
    cmd_bcast <= bc;
    @(posedge core_clk);
    while (cmd_ready !== 1'b1) @(posedge core_clk);
    cmd_valid <= 1'b0;
    // a released word must not keep looking like the last command
    cmd_word <= ~w;
    cmd_secure <= ~sec;
    cmd_bcast <= 1'b0;
  endtask : send
endmodule : tlbri_cmd_src

/* File: tb/tlbri_top_bench.sv */
// self-checking bench: fills entries, issues commands, checks drops and error pulses
// assumes the command source model answers for the software side
`timescale 1ns/1ns
module tlbri_top_bench;
  import tlbri_pkg::*;
  logic core_clk, rst_n, reg_wr, reg_rd, fill_valid, fill_table, cmd_valid, cmd_secure, cmd_bcast, cmd_ready;
  logic ns_cmd_err, s_cmd_err, cmd_done, fill_global;
  logic [7:0] reg_addr, entry_valid;
  logic [31:0] reg_wdata, reg_rdata;
  logic [127:0] cmd_word;
  logic [2:0] fill_idx, fill_regime;
  logic [15:0] fill_vmt;
  logic [1:0] fill_tg, fill_level;
  logic [5:0] fill_span;
  logic [35:0] fill_va_page;
  int err_total = 0;
  logic bc_mode = 1'b0;
  int cmp_count = 0;
  tlbri_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .cmd_secure(cmd_secure), .cmd_bcast(cmd_bcast), .cmd_ready(cmd_ready), .fill_valid(fill_valid),
    .fill_idx(fill_idx), .fill_regime(fill_regime), .fill_vmt(fill_vmt), .fill_ast(16'h0000),
    .fill_global(fill_global), .fill_tg(fill_tg), .fill_level(fill_level), .fill_table(fill_table),
    .fill_span(fill_span), .fill_va_page(fill_va_page), .ns_cmd_err(ns_cmd_err), .s_cmd_err(s_cmd_err),
    .cmd_done(cmd_done), .entry_valid(entry_valid));
  tlbri_cmd_src src_u (.core_clk(core_clk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .cmd_secure(cmd_secure), .cmd_bcast(cmd_bcast));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  task fill(input logic [2:0] i, rg, input logic [15:0] v, input logic [1:0] tg, lv, input logic tb,
            input logic [5:0] sp, input logic [35:0] pg);
    @(posedge core_clk);
    {fill_valid, fill_idx, fill_regime, fill_vmt, fill_tg, fill_level} <= {1'b1, i, rg, v, tg, lv};
    {fill_table, fill_span, fill_va_page} <= {tb, sp, pg};
    @(posedge core_clk);
    fill_valid <= 1'b0;
  endtask : fill
  function automatic logic [127:0] mk(logic [7:0] op, logic lf, logic [4:0] num, sc, logic [15:0] v,
                                      logic [1:0] tg, tl, logic [35:0] pg);
    logic [127:0] w;
    w = '0;
    w[7:0] = op;
    w[9] = lf;
    w[16:12] = num;
    w[24:20] = sc;
    w[47:32] = v;
    w[75:72] = {tg, tl};
    w[111:76] = pg;
    return w;
  endfunction : mk
  // answer stands only in the cycle after the edge that follows the taking edge
  task cmd(input logic [127:0] w, input logic sec, ens, es, input logic [7:0] ev);
    src_u.send(w, sec, bc_mode);
    @(posedge core_clk);
    #1 chk(ns_cmd_err, ens);
    chk(s_cmd_err, es);
    chk(cmd_done, !(ens | es));
    chk(entry_valid, ev);
  endtask : cmd
  task t_range;
    rd(REG_CTRL, 32'h00000017);
    rd(8'h10, 32'h00000000);
    fill(0, RG_NS_EL1, 0, TG_4K, 3, 0, 0, 36'h403);
    fill(1, RG_NS_EL1, 0, TG_4K, 3, 0, 0, 36'h404);
    fill(2, RG_NS_EL1, 0, TG_16K, 3, 0, 0, 36'h400);
    fill(3, RG_NS_EL1, 0, TG_4K, 2, 0, 9, 36'h400);
    fill(4, RG_NS_EL1, 0, TG_4K, 1, 1, 18, 36'h0);
    cmd(mk(OP_GUEST_EL1_FLUSH_ADDR_ALL_TAGS, 1, 1, 1, 0, TG_4K, 3, 36'h400), 0, 0, 0, 8'h1e);
    cmd(mk(OP_GUEST_EL1_FLUSH_ADDR_ALL_TAGS, 0, 1, 1, 0, TG_4K, 3, 36'h400), 0, 0, 0, 8'h0e);
    cmd(mk(OP_GUEST_EL1_FLUSH_ADDR_ALL_TAGS, 0, 0, 0, 0, TG_ANY, 0, 36'h400), 0, 0, 0, 8'h02);
    $display("test range done");
  endtask : t_range
  task t_scope;
    wr(REG_CTRL, 32'h00000037);
    fill(0, RG_NS_EL1, 1, TG_4K, 3, 0, 0, 36'h1);
    fill(2, RG_SECURE, 1, TG_4K, 3, 0, 0, 36'h1);
    fill(3, RG_MONITOR, 0, TG_4K, 3, 0, 0, 36'h1);
    fill(4, RG_HYP, 0, TG_4K, 3, 0, 0, 36'h1);
    fill(5, RG_HYP_HOST, 0, TG_4K, 3, 0, 0, 36'h1);
    fill(6, RG_NS_EL1, 2, TG_4K, 3, 0, 0, 36'h1);
    cmd(mk(OP_GUEST_EL1_FLUSH_ALL, 0, 0, 0, 1, 0, 0, 0), 0, 0, 0, 8'h7e);
    cmd(mk(OP_GUEST_EL1_FLUSH_ALL, 0, 0, 0, 0, 0, 0, 0), 1, 0, 0, 8'h7a);
    cmd(mk(OP_MONITOR_FLUSH_ALL, 0, 0, 0, 0, 0, 0, 0), 0, 1, 0, 8'h7a);
    cmd(mk(OP_MONITOR_FLUSH_ALL, 0, 0, 0, 0, 0, 0, 0), 1, 0, 0, 8'h72);
    wr(REG_CTRL, 32'h00000035);
    cmd(mk(OP_HYP_FLUSH_ALL, 0, 0, 0, 0, 0, 0, 0), 0, 1, 0, 8'h72);
    wr(REG_CTRL, 32'h00000037);
    cmd(mk(OP_HYP_FLUSH_ALL, 0, 0, 0, 0, 0, 0, 0), 1, 0, 0, 8'h42);
    wr(REG_CTRL, 32'h00000027);
    cmd(mk(OP_GUEST_EL1_FLUSH_ALL, 0, 0, 0, 2, 0, 0, 0), 0, 1, 0, 8'h42);
    wr(REG_CTRL, 32'h00000037);
    cmd(mk(OP_GUEST_EL1_FLUSH_ADDR_ALL_TAGS, 0, 0, 0, 2, TG_4K, 0, 36'h1), 0, 1, 0, 8'h42);
    cmd(mk(OP_GUEST_EL1_FLUSH_ADDR_ALL_TAGS, 0, 0, 0, 2, TG_16K, 1, 36'h0), 1, 0, 1, 8'h42);
    rd(REG_ERRCNT, 32'h00000005);
    rd(REG_STATUS, 32'h00000006);
    bc_mode = 1'b1;
    wr(REG_CTRL, 32'h00000033);
    cmd(mk(OP_GUEST_EL1_FLUSH_ALL, 0, 0, 0, 2, 0, 0, 0), 0, 0, 0, 8'h42);
    wr(REG_CTRL, 32'h00000037);
    cmd(mk(OP_GUEST_EL1_FLUSH_ALL, 0, 0, 0, 2, 0, 0, 0), 0, 0, 0, 8'h02);
    bc_mode = 1'b0;
    wr(REG_CTRL, 32'h00000036);
    cmd(mk(OP_GUEST_EL1_FLUSH_ADDR_ALL_TAGS, 0, 0, 0, 0, TG_4K, 0, 36'h404), 0, 0, 0, 8'h00);
    $display("test scope done");
  endtask : t_scope
  initial begin
    rst_n = 1'b0;
    {reg_wr, reg_rd, fill_valid, fill_table, fill_global} = '0;
    {reg_addr, reg_wdata, fill_idx, fill_regime, fill_vmt, fill_tg, fill_level, fill_span, fill_va_page} = '0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    #1 chk(entry_valid, 8'h00);
    chk(cmd_ready, 1'b1);
    t_range;
    t_scope;
    close_out;
  end
  initial begin
    repeat (3000) @(posedge core_clk);
    err_total++;
    close_out;
  end
endmodule : tlbri_top_bench
